// *** shared/dataport_pkg.sv ***
// Constants shared by the writeback and scratch block logic
package dataport_pkg;
	localparam int DW_W = 32;
	localparam int REG_W = 256;
	localparam int NUM_SRC = 8;
	localparam int KIND_W = 2;
	localparam logic [1:0] KIND_READ = 2'h0;
	localparam logic [1:0] KIND_ATOMIC = 2'h1;
	localparam logic [1:0] KIND_SCRATCH = 2'h2;
	localparam logic [1:0] SIMD_16 = 2'h0;
	localparam logic [1:0] SIMD_8 = 2'h1;
	localparam logic [1:0] SIMD_4X2 = 2'h2;
	localparam logic [1:0] FMT_RAW = 2'h0;
	localparam logic [1:0] FMT_SINT = 2'h1;
	localparam logic [1:0] FMT_UINT = 2'h2;
	localparam logic [1:0] FMT_FLOAT = 2'h3;
	localparam int DESC_W = 18;
	localparam int DESC_DIR_BIT = 17;
	localparam int DESC_MODE_BIT = 16;
	localparam int DESC_BLK_LO = 12;
	localparam int DESC_OFF_W = 12;
	localparam logic [1:0] BLK_ONE = 2'h0;
	localparam logic [1:0] BLK_TWO = 2'h1;
	localparam logic [1:0] BLK_FOUR = 2'h3;
	localparam logic [7:0] BTI_STATELESS = 8'hff;
	localparam int S16_MAX_REGS = 8;
	localparam int S8_MAX_REGS = 4;
	localparam logic [REG_W-1:0] BYTE_KEEP = {8{32'h000000ff}};
endpackage

// *** tb/dataport_writeback_test.sv ***
// Self-checking bench for the writeback and scratch engine
`timescale 1ns/1ps
`default_nettype none
module dataport_writeback_test;
	import dataport_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_ready;
	logic [1:0] req_kind = '0, req_simd = '0, req_fmt = '0;
	logic [3:0] req_chan_mask = '0;
	logic [31:0] req_exec_mask = '0;
	logic req_upper_half_selector = 1'b0, req_ret_data = 1'b0;
	logic req_compare_write_64bit_op = 1'b0, req_typed = 1'b0;
	logic req_tilew = 1'b0, slow = 1'b0;
	logic [DESC_W-1:0] req_desc = '0;
	logic [6:0] req_dst_base = 7'h10;
	logic [NUM_SRC*REG_W-1:0] req_src;
	logic [12:0] scratch_size_hw = 13'h1000;
	logic grf_we, done, mem_req, mem_we, mem_ack;
	logic [6:0] grf_addr;
	logic [REG_W-1:0] grf_wdata, mem_wdata, mem_rdata;
	logic [7:0] grf_dw_en, mem_bti, mem_dw_en;
	logic [DESC_OFF_W-1:0] mem_addr;
	logic [REG_W-1:0] gd [8];
	logic [7:0] ge [8];
	logic [6:0] ga [8];
	int n, nm, mismatches = 0, n_tests = 0;
	always #20 clk = ~clk;
	dataport_writeback dataport_writeback_i (.clk, .resetn, .req_valid,
		.req_ready, .req_kind, .req_simd, .req_chan_mask, .req_exec_mask,
		.req_upper_half_selector, .req_ret_data, .req_compare_write_64bit_op,
		.req_typed, .req_fmt, .req_tilew, .req_desc, .req_dst_base, .req_src,
		.scratch_size_hw, .grf_we, .grf_addr, .grf_wdata, .grf_dw_en, .done,
		.mem_req, .mem_we, .mem_addr, .mem_bti, .mem_wdata, .mem_dw_en,
		.mem_ack, .mem_rdata);
	scratch_mem_model scratch_mem_model_i (.clk, .slow, .mem_req, .mem_we,
		.mem_addr, .mem_wdata, .mem_dw_en, .mem_ack, .mem_rdata);
	initial
		for (int i = 0; i < 64; i++)
			req_src[i*32+:32] = 32'h8c3a5100 + 32'(i);
	function logic [255:0] sr(input int i);
		return req_src[i*256+:256];
	endfunction
	function logic [255:0] dwm(input logic [7:0] en);
		for (int d = 0; d < 8; d++)
			dwm[d*32+:32] = {32{en[d]}};
	endfunction
	task chk(input logic [255:0] s, input logic [255:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task send;
		int i;
		i = 0;
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && i < 50) begin
			@(negedge clk);
			i++;
		end
		@(negedge clk);
		req_valid = 1'b0;
	endtask
	task take;
		n = 0;
		nm = 0;
		for (int t = 0; t < 300 && done !== 1'b1; t++) begin
			@(negedge clk);
			if (mem_req === 1'b1) begin
				nm++;
				chk(mem_bti, BTI_STATELESS);
			end
			if (grf_we === 1'b1 && n < 8) begin
				ga[n] = grf_addr;
				gd[n] = grf_wdata;
				ge[n] = grf_dw_en;
				n++;
			end
		end
		chk(done, 1'b1);
	endtask
	task s8_read;
		req_kind = KIND_READ;
		req_simd = SIMD_8;
		req_chan_mask = 4'h6;
		req_exec_mask = 32'h5a;
		send;
		take;
		chk(n, 2);
		chk(ga[1], req_dst_base + 7'h1);
		chk(gd[1], sr(6));
		chk(ge[1], 8'h5a);
	endtask
	task s16_read;
		req_simd = SIMD_16;
		req_exec_mask = 32'hf00f;
		for (int m = 0; m < 2; m++) begin
			req_chan_mask = m ? 4'h0 : 4'h2;
			send;
			take;
			chk(n, m ? 8 : 6);
			for (int i = 0; i < n; i++) begin
				chk(gd[i], sr((m || i < 2) ? i : i + 2));
				chk(ge[i], i[0] ? 8'hf0 : 8'h0f);
			end
		end
	endtask
	task s8_format;
		logic [255:0] e;
		req_simd = SIMD_8;
		req_chan_mask = 4'he;
		req_exec_mask = 32'hff;
		req_tilew = 1'b1;
		send;
		take;
		chk(gd[0], sr(0) & BYTE_KEEP);
		req_tilew = 1'b0;
		req_typed = 1'b1;
		req_fmt = FMT_SINT;
		send;
		take;
		e = sr(0);
		for (int d = 0; d < 8; d++)
			e[d*32+31] = e[d*32+30];
		chk(gd[0], e);
		req_fmt = FMT_UINT;
		send;
		take;
		chk(gd[0], sr(0));
		req_typed = 1'b0;
	endtask
	task s4x2_read;
		req_simd = SIMD_4X2;
		req_chan_mask = 4'h5;
		req_exec_mask = 32'h20;
		send;
		take;
		chk(n, 1);
		chk(ge[0], 8'ha0);
		chk(gd[0] & dwm(8'ha0), sr(0) & dwm(8'ha0));
	endtask
	task atomics;
		int cnt [6] = '{2, 4, 1, 2, 1, 1};
		logic [7:0] x;
		req_kind = KIND_ATOMIC;
		req_exec_mask = 32'h3c81;
		req_ret_data = 1'b1;
		for (int c = 0; c < 6; c++) begin
			req_simd = 2'(c / 2);
			req_compare_write_64bit_op = c[0];
			send;
			take;
			chk(n, cnt[c]);
			for (int i = 0; i < n; i++) begin
				x = c > 3 ? (c[0] ? 8'h33 : 8'h11) : (c < 2 && i[0]) ? 8'h3c : 8'h81;
				chk(ge[i], x);
				chk(gd[i] & dwm(x), sr(i) & dwm(x));
			end
		end
		req_ret_data = 1'b0;
		send;
		take;
		chk(n, 0);
	endtask
	task scratch;
		logic [7:0] wm, rm;
		req_kind = KIND_SCRATCH;
		req_upper_half_selector = 1'b1;
		req_exec_mask = 32'hff3cffff;
		req_desc = {2'b11, 2'b00, BLK_FOUR, 12'h005};
		send;
		take;
		chk(nm > 0, 1'b1);
		req_upper_half_selector = 1'b0;
		req_exec_mask = 32'h0180;
		req_desc = {2'b00, 2'b00, BLK_FOUR, 12'h005};
		slow = 1'b1;
		send;
		take;
		chk(n, 4);
		for (int k = 0; k < 4; k++) begin
			wm = k[0] ? 8'hff : 8'h3c;
			rm = k[0] ? 8'h0f : 8'hf0;
			chk(ge[k], rm);
			chk(gd[k] & dwm(rm), sr(k) & dwm(wm & rm));
		end
		slow = 1'b0;
		scratch_size_hw = 13'h7;
		req_desc = {2'b11, 2'b00, BLK_ONE, 12'h007};
		send;
		take;
		chk(nm, 0);
		req_exec_mask = 32'hff50;
		req_desc = {2'b01, 2'b00, BLK_TWO, 12'h006};
		send;
		take;
		chk(ge[0], 8'h50);
		chk(gd[0] & dwm(8'h50), sr(1) & dwm(8'h50));
		chk(ge[1], 8'hff);
		chk(gd[1], 0);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#(40 * 6000);
		mismatches++;
		conclude;
	end
	initial begin
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		s8_read;
		s16_read;
		s8_format;
		s4x2_read;
		atomics;
		scratch;
		conclude;
	end
endmodule // dataport_writeback_test
`default_nettype wire

// *** tb/scratch_mem_model.sv ***
// Scratch memory answering the block's hword requests
`timescale 1ns/1ps
`default_nettype none
module scratch_mem_model (
	input wire logic clk,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [dataport_pkg::DESC_OFF_W-1:0] mem_addr,
	input wire logic [dataport_pkg::REG_W-1:0] mem_wdata,
	input wire logic [7:0] mem_dw_en,
	output logic mem_ack,
	output logic [dataport_pkg::REG_W-1:0] mem_rdata
);
	logic [dataport_pkg::REG_W-1:0] mem [int];
	int wait_n = 0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = '0;
	end
	always @(negedge clk) begin
		mem_ack <= 1'b0;
		// Stale data must not look valid after the answer
		mem_rdata <= ~mem_rdata;
		if (mem_req === 1'b1 && !mem_ack) begin
			if (wait_n < (slow ? 3 : 0)) begin
				wait_n <= wait_n + 1;
			end else begin
				wait_n <= 0;
				mem_ack <= 1'b1;
				if (!mem.exists(mem_addr))
					mem[mem_addr] = '0;
				if (mem_we) begin
					for (int d = 0; d < 8; d++)
						if (mem_dw_en[d])
							mem[mem_addr][d*32+:32] = mem_wdata[d*32+:32];
				end else begin
					mem_rdata <= mem[mem_addr];
				end
			end
		end
	end
endmodule // scratch_mem_model
`default_nettype wire

// *** verilog/dataport_writeback.sv ***
// Writeback assembly and scratch block transfer engine
`timescale 1ns/1ps
`default_nettype none
module dataport_writeback (
	input wire logic clk,
	input wire logic resetn,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [dataport_pkg::KIND_W-1:0] req_kind,
	input wire logic [1:0] req_simd,
	input wire logic [3:0] req_chan_mask,
	input wire logic [31:0] req_exec_mask,
	input wire logic req_upper_half_selector,
	input wire logic req_ret_data,
	input wire logic req_compare_write_64bit_op,
	input wire logic req_typed,
	input wire logic [1:0] req_fmt,
	input wire logic req_tilew,
	input wire logic [dataport_pkg::DESC_W-1:0] req_desc,
	input wire logic [6:0] req_dst_base,
	input wire logic [dataport_pkg::NUM_SRC*dataport_pkg::REG_W-1:0] req_src,
	input wire logic [12:0] scratch_size_hw,
	output logic grf_we,
	output logic [6:0] grf_addr,
	output logic [dataport_pkg::REG_W-1:0] grf_wdata,
	output logic [7:0] grf_dw_en,
	output logic done,
	output logic mem_req,
	output logic mem_we,
	output logic [dataport_pkg::DESC_OFF_W-1:0] mem_addr,
	output logic [7:0] mem_bti,
	output logic [dataport_pkg::REG_W-1:0] mem_wdata,
	output logic [7:0] mem_dw_en,
	input wire logic mem_ack,
	input wire logic [dataport_pkg::REG_W-1:0] mem_rdata
);
	import dataport_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SREQ = 3'b001,
		ST_SWAIT = 3'b011,
		ST_WRITE = 3'b010,
		ST_DONE = 3'b110
	} state_e;

	function automatic logic [7:0] scr_enables(input logic [15:0] em,
		input logic [3:0] k, input logic dword_mode);
		logic [7:0] b;
		b = k[0] ? em[15:8] : em[7:0];
		if (dword_mode)
			scr_enables = b;
		else
			scr_enables = {{4{|b[7:4]}}, {4{|b[3:0]}}};
	endfunction

	logic rs1_q;
	logic rs2_q;
	logic rst_n;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end
	assign rst_n = rs2_q;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	state_e state_q, state_d;
	logic [3:0] step_q, step_d;
	logic [1:0] kind_q, simd_q, fmt_q;
	logic [3:0] cmask_q;
	logic [15:0] em_q;
	logic ret_q, cmp64_q, typed_q, tilew_q;
	logic [DESC_W-1:0] desc_q;
	logic [6:0] base_q;
	logic [NUM_SRC*REG_W-1:0] src_q;
	logic [12:0] size_q;
	logic grf_we_d, done_d, mem_req_d, mem_we_d, ready_d;
	logic [6:0] grf_addr_d;
	logic [REG_W-1:0] grf_wdata_d, mem_wdata_d;
	logic [7:0] grf_dw_en_d, mem_dw_en_d;
	logic [DESC_OFF_W-1:0] mem_addr_d;
	logic [REG_W-1:0] slc_data;
	logic [7:0] slc_en;
	logic [3:0] slc_n;
	logic [3:0] scr_n;
	logic [12:0] scr_full;
	logic scr_oob;
	logic scr_wr;
	logic [7:0] scr_en;
	logic accept;
	logic last;

	writeback_slicer writeback_slicer_i (
		.kind(kind_q),
		.simd(simd_q),
		.chan_mask(cmask_q),
		.exec_mask(em_q),
		.ret_data(ret_q),
		.cmp64(cmp64_q),
		.typed(typed_q),
		.fmt(fmt_q),
		.tilew(tilew_q),
		.src(src_q),
		.step(step_q),
		.reg_data(slc_data),
		.dw_en(slc_en),
		.nregs(slc_n)
	);

	always_comb begin
		case (desc_q[DESC_BLK_LO +: 2])
			BLK_TWO: scr_n = 4'h2;
			BLK_FOUR: scr_n = 4'h4;
			default: scr_n = 4'h1; // Reserved code is run as one register
		endcase
	end

	// Hword address may run past the 12-bit field; the 13-bit sum is outside only when not below the size
	assign scr_full = {1'b0, desc_q[DESC_OFF_W-1:0]}
		+ {9'h0, step_q};
	assign scr_oob = scr_full >= size_q;
	assign scr_wr = desc_q[DESC_DIR_BIT];
	assign scr_en = scr_enables(em_q, step_q, desc_q[DESC_MODE_BIT]);
	assign accept = req_valid && req_ready;
	assign last = (kind_q == KIND_SCRATCH) ? (step_q + 4'h1 == scr_n)
		: (step_q + 4'h1 == slc_n);

	always_comb begin
		state_d = state_q;
		step_d = step_q;
		ready_d = 1'b0;
		grf_we_d = 1'b0;
		grf_addr_d = grf_addr;
		grf_wdata_d = grf_wdata;
		grf_dw_en_d = grf_dw_en;
		done_d = 1'b0;
		mem_req_d = 1'b0;
		mem_we_d = mem_we;
		mem_addr_d = mem_addr;
		mem_wdata_d = mem_wdata;
		mem_dw_en_d = mem_dw_en;
		case (state_q)
			ST_IDLE: begin
				ready_d = !accept;
				step_d = 4'h0;
				if (accept)
					state_d = (req_kind == KIND_SCRATCH) ? ST_SREQ : ST_WRITE;
			end
			ST_WRITE: begin
				if (slc_n == 4'h0) begin
					state_d = ST_DONE;
				end else begin
					grf_we_d = 1'b1;
					grf_addr_d = base_q + {3'h0, step_q};
					grf_wdata_d = slc_data;
					grf_dw_en_d = slc_en;
					step_d = step_q + 4'h1;
					if (last)
						state_d = ST_DONE;
				end
			end
			ST_SREQ: begin
				mem_addr_d = scr_full[DESC_OFF_W-1:0];
				mem_we_d = scr_wr;
				mem_dw_en_d = scr_en;
				mem_wdata_d = src_q[step_q[1:0]*REG_W +: REG_W];
				if (scr_oob) begin
					// Nothing reaches memory; a read still lands as zeros
					grf_we_d = !scr_wr;
					grf_addr_d = base_q + {3'h0, step_q};
					grf_wdata_d = '0;
					grf_dw_en_d = scr_en;
					step_d = step_q + 4'h1;
					state_d = last ? ST_DONE : ST_SREQ;
				end else begin
					mem_req_d = 1'b1;
					state_d = ST_SWAIT;
				end
			end
			ST_SWAIT: begin
				mem_req_d = !mem_ack;
				if (mem_ack) begin
					grf_we_d = !mem_we;
					grf_addr_d = base_q + {3'h0, step_q};
					grf_wdata_d = mem_rdata;
					grf_dw_en_d = mem_dw_en;
					step_d = step_q + 4'h1;
					state_d = last ? ST_DONE : ST_SREQ;
				end
			end
			ST_DONE: begin
				// Raised one cycle after the final register write
				done_d = 1'b1;
				ready_d = 1'b1;
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			step_q <= 4'h0;
			req_ready <= 1'b0;
			grf_we <= 1'b0;
			grf_addr <= 7'h00;
			grf_wdata <= '0;
			grf_dw_en <= 8'h00;
			done <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= '0;
			mem_bti <= BTI_STATELESS;
			mem_wdata <= '0;
			mem_dw_en <= 8'h00;
		end else begin
			state_q <= state_d;
			step_q <= step_d;
			req_ready <= ready_d;
			grf_we <= grf_we_d;
			grf_addr <= grf_addr_d;
			grf_wdata <= grf_wdata_d;
			grf_dw_en <= grf_dw_en_d;
			done <= done_d;
			mem_req <= mem_req_d;
			mem_we <= mem_we_d;
			mem_addr <= mem_addr_d;
			mem_bti <= BTI_STATELESS;
			mem_wdata <= mem_wdata_d;
			mem_dw_en <= mem_dw_en_d;
		end
	end

	// Held for the whole message; read only after a take, so no reset
	always_ff @(posedge clk) begin
		if (accept) begin
			kind_q <= req_kind;
			simd_q <= req_simd;
			fmt_q <= req_fmt;
			cmask_q <= req_chan_mask;
			// Upper half of a 32-wide mask only for flagged scratch messages
			em_q <= (req_upper_half_selector && req_kind == KIND_SCRATCH)
				? req_exec_mask[31:16] : req_exec_mask[15:0];
			ret_q <= req_ret_data;
			cmp64_q <= req_compare_write_64bit_op;
			typed_q <= req_typed;
			tilew_q <= req_tilew;
			desc_q <= req_desc;
			base_q <= req_dst_base;
			src_q <= req_src;
			size_q <= scratch_size_hw;
		end
	end

	logic [3:0] wr_cnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wr_cnt_q <= 4'h0;
		else if (accept)
			wr_cnt_q <= 4'h0;
		else if (grf_we)
			wr_cnt_q <= wr_cnt_q + 4'h1;
	end

	s16_count_a: assert property (done && kind_q == KIND_READ
		&& simd_q == SIMD_16 |-> wr_cnt_q == 4'(8 - 2 * $countones(cmask_q)))
		else $error("16-slot read register count wrong");
	s8_count_a: assert property (done && kind_q == KIND_READ
		&& simd_q == SIMD_8 |-> wr_cnt_q == 4'(4 - $countones(cmask_q)))
		else $error("8-slot read register count wrong");
	x2_one_reg_a: assert property (done && kind_q == KIND_READ
		&& simd_q == SIMD_4X2 |-> wr_cnt_q == 4'h1)
		else $error("two-slot read not one register");
	atomic_silent_a: assert property (done && kind_q == KIND_ATOMIC
		&& !ret_q |-> wr_cnt_q == 4'h0)
		else $error("atomic wrote without return request");
	dest_seq_a: assert property (grf_we
		|-> grf_addr == base_q + {3'h0, wr_cnt_q} && !done)
		else $error("destination index not consecutive");
	tilew_zero_a: assert property (grf_we && kind_q == KIND_READ
		&& simd_q == SIMD_8 && tilew_q |-> (grf_wdata & ~BYTE_KEEP) == '0)
		else $error("byte-tiled read upper bits not zero");
	x2_atomic_en_a: assert property (grf_we && kind_q == KIND_ATOMIC
		&& simd_q == SIMD_4X2 |-> (grf_dw_en & (cmp64_q ? 8'hcc : 8'hee)) == 8'h00)
		else $error("two-slot atomic wrote reserved dword");
	oob_drop_a: assert property (state_q == ST_SREQ && scr_oob
		|=> !mem_req && (grf_we == !scr_wr))
		else $error("out-of-range scratch reached memory");
	oword_en_a: assert property (mem_req && !desc_q[DESC_MODE_BIT]
		|-> mem_dw_en[3:0] inside {4'h0, 4'hf}
		&& mem_dw_en[7:4] inside {4'h0, 4'hf})
		else $error("oword enables split");
	bti_fixed_a: assert property (mem_req
		|-> mem_bti == BTI_STATELESS)
		else $error("scratch not stateless");

	scratch_rd_c: cover property (done && kind_q == KIND_SCRATCH
		&& !scr_wr && wr_cnt_q == 4'h4);
	s16_read_c: cover property (done && kind_q == KIND_READ
		&& simd_q == SIMD_16 && wr_cnt_q == 4'h8);
	cmp64_c: cover property (done && kind_q == KIND_ATOMIC
		&& cmp64_q && wr_cnt_q == 4'h4);
endmodule // dataport_writeback
`default_nettype wire

// *** verilog/writeback_slicer.sv ***
// Combinational builder of one writeback register for reads and atomics
`timescale 1ns/1ps
`default_nettype none
module writeback_slicer (
	input wire logic [1:0] kind,
	input wire logic [1:0] simd,
	input wire logic [3:0] chan_mask,
	input wire logic [15:0] exec_mask,
	input wire logic ret_data,
	input wire logic cmp64,
	input wire logic typed,
	input wire logic [1:0] fmt,
	input wire logic tilew,
	input wire logic [dataport_pkg::NUM_SRC*dataport_pkg::REG_W-1:0] src,
	input wire logic [3:0] step,
	output logic [dataport_pkg::REG_W-1:0] reg_data,
	output logic [7:0] dw_en,
	output logic [3:0] nregs
);
	import dataport_pkg::*;

	function automatic logic [1:0] nth_chan(input logic [3:0] en,
		input logic [1:0] n);
		logic [2:0] seen;
		nth_chan = 2'h0;
		seen = 3'h0;
		for (int c = 0; c < 4; c++) begin
			if (en[c]) begin
				if (seen[1:0] == n && seen[2] == 1'b0)
					nth_chan = c[1:0];
				seen = seen + 3'h1;
			end
		end
	endfunction

	logic [3:0] en;
	logic [2:0] cnt;
	logic [1:0] ch;
	logic [2:0] src_idx;
	logic [REG_W-1:0] raw;
	logic act0;
	logic act1;

	assign en = ~chan_mask;
	assign act0 = |exec_mask[3:0];
	assign act1 = |exec_mask[7:4];

	always_comb begin
		cnt = 3'h0;
		for (int c = 0; c < 4; c++)
			cnt = cnt + {2'h0, en[c]};
		ch = 2'h0;
		src_idx = step[2:0];
		nregs = 4'h0;
		dw_en = 8'h00;
		if (kind == KIND_READ) begin
			case (simd)
				SIMD_16: begin
					// Unmasked channels close up, two registers each
					nregs = {cnt, 1'b0};
					ch = nth_chan(en, step[2:1]);
					src_idx = {ch, step[0]};
					dw_en = step[0] ? exec_mask[15:8] : exec_mask[7:0];
				end
				SIMD_8: begin
					nregs = {1'b0, cnt};
					ch = nth_chan(en, step[1:0]);
					src_idx = {ch, 1'b0};
					dw_en = exec_mask[7:0];
				end
				SIMD_4X2: begin
					nregs = 4'h1;
					src_idx = 3'h0;
					dw_en = {en & {4{act1}}, en & {4{act0}}};
				end
				default: nregs = 4'h0;
			endcase
		end else if (kind == KIND_ATOMIC && ret_data) begin
			case (simd)
				SIMD_16: begin
					nregs = cmp64 ? 4'h4 : 4'h2;
					dw_en = step[0] ? exec_mask[15:8] : exec_mask[7:0];
				end
				SIMD_8: begin
					nregs = cmp64 ? 4'h2 : 4'h1;
					dw_en = exec_mask[7:0];
				end
				SIMD_4X2: begin
					nregs = 4'h1;
					dw_en = {2'h0, cmp64 & act1, act1,
						2'h0, cmp64 & act0, act0};
				end
				default: nregs = 4'h0;
			endcase
		end
	end

	assign raw = src[src_idx*REG_W +: REG_W];

	always_comb begin
		reg_data = raw;
		if (kind == KIND_READ && simd == SIMD_8) begin
			if (tilew)
				reg_data = raw & BYTE_KEEP;
			else if (typed && fmt == FMT_SINT)
				for (int d = 0; d < 8; d++)
					reg_data[d*DW_W+31] = raw[d*DW_W+30];
		end
	end
endmodule // writeback_slicer
`default_nettype wire
